// file: common/hrc_pkg.sv
// package of constants and types for the core halt/run control block
package hrc_pkg;
  localparam int unsigned PC_W = 32;
  localparam int unsigned CAUSE_W = 3;
  localparam logic [2:0] CAUSE_TRIGGER = 3'h2;
  localparam logic [2:0] CAUSE_BREAK = 3'h1;
  localparam logic [2:0] CAUSE_HALTREQ = 3'h3;
  localparam logic [2:0] CAUSE_STEP = 3'h4;
  localparam logic [2:0] CAUSE_NONE = 3'h0;
  localparam int unsigned SYNC_STAGES = 2;

  typedef enum logic [2:0] {
    HRC_RUN = 3'b000,
    HRC_QUIESCE_SLEEP = 3'b001,
    HRC_SLEEP_HALT = 3'b010,
    HRC_QUIESCE_DEBUG = 3'b011,
    HRC_DEBUG_HALT = 3'b100,
    HRC_STEP = 3'b101
  } hrc_state_t;
endpackage : hrc_pkg

// file: dv/hrc_core_halt_run_control_bench.sv
// self-checking bench for the halt/run control block
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; \
  $display("mismatch at %0t: %h vs %h", $time, a, b); end end
module hrc_core_halt_run_control_bench;
  logic clock_i, rstn_i, mc_reset_run_i, dbg_step_i, quiesced_i, slow;
  logic [7:0] ev;
  logic [3:0] go, req, ack, fin;
  logic [31:0] pc, dbg_pc_o;
  logic [2:0] dbg_cause_o;
  logic halt_status_o, debug_mode_o, brkpt_status_o, illegal_acc_o, stall_o;
  int mismatches = 0;
  int checked = 0;
  int seed = 32'h7831;
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  hrc_core_halt_run_control dut (.clock_i, .rstn_i, .pm_halt_req_i(req[0]), .pm_run_req_i(req[1]),
    .mc_halt_req_i(req[2]), .mc_run_req_i(req[3]), .mc_reset_run_i, .dbg_halt_req_i(ev[0]),
    .dbg_resume_req_i(ev[1]), .dbg_step_i, .brkpt_halt_i(ev[2]), .trig_halt_i(ev[3]),
    .step_done_i(ev[6]), .fw_halt_wr_i(ev[4]), .dmode_reg_acc_i(ev[5]), .quiesced_i,
    .wake_i(ev[7]), .next_pc_i(pc), .pm_halt_ack_o(ack[0]), .pm_run_ack_o(ack[1]),
    .mc_halt_ack_o(ack[2]), .mc_run_ack_o(ack[3]), .halt_status_o, .debug_mode_o,
    .brkpt_status_o, .stall_o, .illegal_acc_o, .dbg_cause_o, .dbg_pc_o);
  hrc_requester u_req[3:0] (.clock_i, .go_i(go), .slow_i({4{slow}}), .ack_i(ack), .req_o(req),
    .done_o(fin));
  // random quiesce latency and partner pace
  always @(negedge clock_i) begin
    quiesced_i <= ($random(seed) & 3) != 0;
    slow <= $random(seed) & 1;
  end
  function automatic logic [2:0] exp_cause(input int k);
    return k == 2 ? hrc_pkg::CAUSE_BREAK : k == 3 ? hrc_pkg::CAUSE_TRIGGER : hrc_pkg::CAUSE_HALTREQ;
  endfunction : exp_cause
  task automatic run(input int n);
    repeat (n) @(negedge clock_i);
  endtask : run
  task automatic pulse(input int k);
    ev[k] = 1'b1;
    run(1);
    ev[k] = 1'b0;
    run(1);
  endtask : pulse
  task automatic wait_fin(input int k);
    int n;
    n = 0;
    while (fin[k] !== 1'b1 && n < 200) begin
      run(1);
      n++;
    end
    `CHK(fin[k], 1'b1)
  endtask : wait_fin
  task automatic hs(input int k, input bit w);
    go[k] = 1'b1;
    run(1);
    go[k] = 1'b0;
    run(2);
    if (w) wait_fin(k);
  endtask : hs
  task automatic rst(input logic sr);
    rstn_i = 1'b0;
    mc_reset_run_i = sr;
    run(20);
    rstn_i = 1'b1;
    run(3);
  endtask : rst
  task automatic finish_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test
  initial begin
    repeat (20000) @(posedge clock_i);
    mismatches++;
    finish_test();
  end
  initial begin
    rstn_i = 1'b0;
    dbg_step_i = 1'b0;
    ev = 8'h00;
    go = 4'h0;
    pc = 32'h0000_1000;
    rst(1'b1);
    `CHK({ack, halt_status_o, debug_mode_o, brkpt_status_o}, 7'h00)
    hs(0, 1);
    `CHK(halt_status_o, 1'b1)
    hs(1, 1);
    `CHK(halt_status_o, 1'b0)
    hs(1, 1);
    `CHK(halt_status_o, 1'b0)
    pulse(4);
    run(6);
    `CHK({halt_status_o, debug_mode_o}, 2'b10)
    pulse(7);
    `CHK(halt_status_o, 1'b0)
    $display("test power done");
    ev = 8'h11;
    run(1);
    ev = 8'h00;
    run(6);
    `CHK({debug_mode_o, halt_status_o, dbg_cause_o}, {2'b10, exp_cause(0)})
    hs(0, 0);
    run(12);
    `CHK({halt_status_o, ack[0]}, 2'b00)
    pulse(1);
    wait_fin(0);
    `CHK({debug_mode_o, halt_status_o}, 2'b01)
    hs(1, 1);
    $display("test debug done");
    for (int k = 2; k < 4; k++) begin
      pulse(k);
      run(6);
      `CHK({debug_mode_o, brkpt_status_o, dbg_cause_o}, {2'b11, exp_cause(k)})
      pulse(1);
      run(3);
      `CHK({debug_mode_o, brkpt_status_o}, 2'b00)
    end
    $display("test breakpoint done");
    pc = $random(seed);
    hs(2, 1);
    `CHK({debug_mode_o, dbg_cause_o, dbg_pc_o}, {1'b1, exp_cause(2'd0), pc})
    pulse(0);
    hs(3, 0);
    run(10);
    `CHK({debug_mode_o, ack[3]}, 2'b10)
    `CHK(stall_o, 1'b1)
    pulse(1);
    wait_fin(3);
    `CHK(debug_mode_o, 1'b0)
    $display("test controller done");
    pulse(0);
    run(6);
    dbg_step_i = 1'b1;
    pulse(1);
    ev = 8'h30;
    run(1);
    `CHK(illegal_acc_o, 1'b1)
    ev = 8'h00;
    run(4);
    `CHK(halt_status_o, 1'b0)
    pulse(6);
    dbg_step_i = 1'b0;
    pulse(1);
    run(3);
    `CHK(debug_mode_o, 1'b0)
    $display("test step done");
    rst(1'b0);
    `CHK(debug_mode_o, 1'b1)
    mc_reset_run_i = 1'b1;
    hs(3, 1);
    `CHK(debug_mode_o, 1'b0)
    $display("test reset done");
    finish_test();
  end
endmodule : hrc_core_halt_run_control_bench

// file: dv/hrc_halt_run_asserts.sv
// concurrent checks on the halt/run control ports
`timescale 1ns/1ps
module hrc_halt_run_asserts (
  input wire logic clock_i, // core clock
  input wire logic rstn_i, // sync reset, active low
  input wire logic pm_halt_req_i, // manager halt request
  input wire logic pm_run_req_i, // manager run request
  input wire logic mc_halt_req_i, // controller halt request
  input wire logic mc_run_req_i, // controller run request
  input wire logic dmode_reg_acc_i, // debug-only access
  input wire logic pm_halt_ack_o, // manager halt ack
  input wire logic pm_run_ack_o, // manager run ack
  input wire logic mc_halt_ack_o, // controller halt ack
  input wire logic mc_run_ack_o, // controller run ack
  input wire logic halt_status_o, // sleep halt status
  input wire logic debug_mode_o, // debug mode status
  input wire logic brkpt_status_o, // breakpoint status
  input wire logic illegal_acc_o // illegal access pulse
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  a_debug_no_sleep: assert property (debug_mode_o |-> !halt_status_o)
    else $error("sleep halt status during debug mode");
  a_pm_halt_ack: assert property ($rose(pm_halt_ack_o) |-> halt_status_o)
    else $error("manager halt ack before sleep halt");
  a_pm_halt_drop: assert property (!pm_halt_req_i [*4] |-> !pm_halt_ack_o)
    else $error("manager halt ack kept after request fell");
  a_pm_run_drop: assert property (!pm_run_req_i [*4] |-> !pm_run_ack_o)
    else $error("manager run ack kept after request fell");
  a_pm_run_state: assert property (pm_run_ack_o |-> !halt_status_o)
    else $error("manager run ack while halted");
  a_mc_halt_hold: assert property (mc_halt_req_i [*3] ##0 mc_halt_ack_o |=> mc_halt_ack_o)
    else $error("controller halt ack dropped early");
  a_mc_halt_mode: assert property ($rose(mc_halt_ack_o) |-> debug_mode_o)
    else $error("controller halt ack outside debug mode");
  a_mc_run_hold: assert property (mc_run_req_i [*3] ##0 mc_run_ack_o |=> mc_run_ack_o)
    else $error("controller run ack dropped early");
  a_mc_run_mode: assert property ($rose(mc_run_ack_o) |-> !debug_mode_o)
    else $error("controller run ack while still in debug");
  a_brk_clear: assert property ($fell(debug_mode_o) |-> !brkpt_status_o)
    else $error("breakpoint status kept after debug exit");
  a_illegal_cause: assert property (illegal_acc_o |-> $past(dmode_reg_acc_i))
    else $error("illegal access flag without access");
endmodule : hrc_halt_run_asserts

bind hrc_core_halt_run_control hrc_halt_run_asserts u_chk (.clock_i, .rstn_i, .pm_halt_req_i,
  .pm_run_req_i, .mc_halt_req_i, .mc_run_req_i, .dmode_reg_acc_i, .pm_halt_ack_o, .pm_run_ack_o,
  .mc_halt_ack_o, .mc_run_ack_o, .halt_status_o, .debug_mode_o, .brkpt_status_o, .illegal_acc_o);

// file: dv/hrc_requester.sv
// four-phase requester standing in for the manager or the controller
`timescale 1ns/1ps
module hrc_requester (
  input wire logic clock_i, // partner clock
  input wire logic go_i, // start one handshake
  input wire logic slow_i, // linger before dropping request
  input wire logic ack_i, // acknowledge from the core
  output logic req_o, // request level
  output logic done_o // handshake finished
);
  logic [1:0] ack_s;
  always @(posedge clock_i) ack_s <= {ack_s[0], ack_i};
  initial begin
    req_o = 1'b0;
    done_o = 1'b1;
    forever begin
      @(posedge clock_i);
      if (go_i) begin
        done_o = 1'b0;
        @(negedge clock_i) req_o = 1'b1;
        while (ack_s[1] !== 1'b1) @(negedge clock_i);
        if (slow_i) repeat (3) @(negedge clock_i);
        req_o = 1'b0;
        while (ack_s[1] !== 1'b0) @(negedge clock_i);
        done_o = 1'b1;
      end
    end
  end
endmodule : hrc_requester

// file: rtl/hrc_core_halt_run_control.sv
// halt/run arbitration and sequencing for the core
`timescale 1ns/1ps
module hrc_core_halt_run_control (
  input wire logic clock_i, // core clock, ungated
  input wire logic rstn_i, // synchronous reset, active low
  input wire logic pm_halt_req_i, // manager halt request, async
  input wire logic pm_run_req_i, // manager run request, async
  input wire logic mc_halt_req_i, // controller debug halt request, async
  input wire logic mc_run_req_i, // controller debug run request, async
  input wire logic mc_reset_run_i, // start state, already synchronized
  input wire logic dbg_halt_req_i, // debugger halt request
  input wire logic dbg_resume_req_i, // debugger resume request
  input wire logic dbg_step_i, // resume carries single-step action
  input wire logic brkpt_halt_i, // software breakpoint with halt action
  input wire logic trig_halt_i, // trigger hit with halt action
  input wire logic step_done_i, // stepped instruction retired
  input wire logic fw_halt_wr_i, // firmware writes halt bit
  input wire logic dmode_reg_acc_i, // access to debug-only register
  input wire logic quiesced_i, // core quiesced
  input wire logic wake_i, // internal wake event from sleep
  input wire logic [31:0] next_pc_i, // next instruction address
  output logic pm_halt_ack_o, // manager halt acknowledge
  output logic pm_run_ack_o, // manager run acknowledge
  output logic mc_halt_ack_o, // controller halt acknowledge
  output logic mc_run_ack_o, // controller run acknowledge
  output logic halt_status_o, // core halted in sleep halt state
  output logic debug_mode_o, // core in debug mode
  output logic brkpt_status_o, // breakpoint or trigger halt hit
  output logic stall_o, // stop issuing instructions
  output logic illegal_acc_o, // debug-only access during step
  output logic [2:0] dbg_cause_o, // recorded debug cause
  output logic [31:0] dbg_pc_o // debug program counter
);
  hrc_pkg::hrc_state_t state_q;
  hrc_pkg::hrc_state_t state_d;
  logic [3:0] async_req;
  logic [3:0] sync_req;
  logic pm_halt_s;
  logic pm_run_s;
  logic mc_halt_s;
  logic mc_run_s;
  logic mc_halt_s_q;
  logic mc_run_s_q;
  logic dbg_src_q; // debugger-side halt owns debug mode
  logic dbg_src_d;
  logic mc_src_q; // controller halt owns debug mode
  logic mc_src_d;
  logic dbg_res_q; // debugger resume collected
  logic dbg_res_d;
  logic mc_res_q; // controller run collected
  logic mc_res_d;
  logic pm_pend_q; // manager halt seen and not yet run
  logic brk_q;
  logic [2:0] cause_q;
  logic [31:0] dpc_q;
  logic boot_q;
  logic illegal_q;
  logic in_debug;
  logic dbg_cause_any;
  logic sleep_cause;
  logic mc_halt_rise;
  logic mc_run_rise;
  logic resume_ok;
  logic enter_debug;
  logic exit_debug;
  logic pm_halt_done;
  logic pm_run_done;
  logic mc_halt_done;
  logic mc_run_done;
  logic [2:0] new_cause;
  logic st_run;
  logic st_sleep;
  logic st_dhalt;
  logic st_step;
  logic step_req;
  logic step_end;
  logic pm_hold;

  // all partner requests cross on the free-running clock
  assign async_req = {mc_run_req_i, mc_halt_req_i, pm_run_req_i, pm_halt_req_i};

  hrc_sync #(
    .WIDTH(4)
  ) u_sync (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .async_i(async_req),
    .sync_o(sync_req)
  );

  assign pm_halt_s = sync_req[0];
  assign pm_run_s = sync_req[1];
  assign mc_halt_s = sync_req[2];
  assign mc_run_s = sync_req[3];
  assign mc_halt_rise = mc_halt_s & ~mc_halt_s_q;
  assign mc_run_rise = mc_run_s & ~mc_run_s_q;

  // every state that counts as debug mode, stepping included
  function automatic logic is_debug_state(input hrc_pkg::hrc_state_t st);
    return (st == hrc_pkg::HRC_QUIESCE_DEBUG) ||
           (st == hrc_pkg::HRC_DEBUG_HALT) ||
           (st == hrc_pkg::HRC_STEP);
  endfunction : is_debug_state

  // state decodes shared by sequencing, acks and status
  assign st_run = (state_q == hrc_pkg::HRC_RUN);
  assign st_sleep = (state_q == hrc_pkg::HRC_SLEEP_HALT);
  assign st_dhalt = (state_q == hrc_pkg::HRC_DEBUG_HALT);
  assign st_step = (state_q == hrc_pkg::HRC_STEP);
  assign in_debug = is_debug_state(state_q);

  // debug causes outrank sleep causes
  assign dbg_cause_any = dbg_halt_req_i | brkpt_halt_i | trig_halt_i | mc_halt_rise;
  // step blocks firmware halt; debug disregards manager halt
  assign sleep_cause = ~in_debug & (pm_halt_s | fw_halt_wr_i);
  assign enter_debug = ~in_debug & dbg_cause_any;

  assign new_cause = (trig_halt_i) ? hrc_pkg::CAUSE_TRIGGER :
                     (brkpt_halt_i) ? hrc_pkg::CAUSE_BREAK :
                     hrc_pkg::CAUSE_HALTREQ;

  // resume/run are only honoured for the source that halted
  assign dbg_res_d = dbg_res_q | (dbg_src_q & dbg_resume_req_i & ~dbg_step_i);
  assign mc_res_d = mc_res_q | (mc_src_q & mc_run_rise);
  assign dbg_src_d = dbg_src_q | (dbg_halt_req_i | brkpt_halt_i | trig_halt_i);
  assign mc_src_d = mc_src_q | mc_halt_rise;
  assign resume_ok = (~dbg_src_q | dbg_res_d) & (~mc_src_q | mc_res_d) &
                     (dbg_src_q | mc_src_q);
  // only a controller-owned exit waits for manager run; a debugger-only
  // exit goes on so a pending manager halt is honoured afterwards
  assign pm_hold = mc_src_q & pm_pend_q & ~pm_run_s;
  assign exit_debug = st_dhalt & resume_ok & ~dbg_halt_req_i & ~pm_hold;
  // stepping only while the debugger alone owns debug mode
  assign step_req = dbg_src_q & dbg_resume_req_i & dbg_step_i & ~mc_src_q;
  assign step_end = st_step & step_done_i;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      hrc_pkg::HRC_RUN: begin
        if (enter_debug) begin
          state_d = hrc_pkg::HRC_QUIESCE_DEBUG;
        end else if (sleep_cause) begin
          state_d = hrc_pkg::HRC_QUIESCE_SLEEP;
        end
      end
      hrc_pkg::HRC_QUIESCE_SLEEP: begin
        if (enter_debug) begin
          state_d = hrc_pkg::HRC_QUIESCE_DEBUG;
        end else if (quiesced_i) begin
          state_d = hrc_pkg::HRC_SLEEP_HALT;
        end
      end
      hrc_pkg::HRC_SLEEP_HALT: begin
        if (enter_debug) begin
          state_d = hrc_pkg::HRC_QUIESCE_DEBUG;
        end else if (pm_run_s | wake_i) begin
          state_d = hrc_pkg::HRC_RUN;
        end
      end
      hrc_pkg::HRC_QUIESCE_DEBUG: begin
        if (quiesced_i) begin
          state_d = hrc_pkg::HRC_DEBUG_HALT;
        end
      end
      hrc_pkg::HRC_DEBUG_HALT: begin
        if (exit_debug) begin
          state_d = hrc_pkg::HRC_RUN;
        end else if (step_req) begin
          state_d = hrc_pkg::HRC_STEP; // controller halt ignores stepping
        end
      end
      hrc_pkg::HRC_STEP: begin
        if (step_done_i) begin
          state_d = hrc_pkg::HRC_DEBUG_HALT;
        end
      end
      default: begin
        state_d = hrc_pkg::HRC_RUN;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      state_q <= hrc_pkg::HRC_RUN;
      boot_q <= 1'b1;
    end else if (boot_q) begin
      boot_q <= 1'b0;
      // start state caught after release, input presynchronized
      state_q <= mc_reset_run_i ? hrc_pkg::HRC_RUN : hrc_pkg::HRC_DEBUG_HALT;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      dbg_src_q <= 1'b0;
      mc_src_q <= 1'b0;
      dbg_res_q <= 1'b0;
      mc_res_q <= 1'b0;
    end else if (boot_q) begin
      mc_src_q <= ~mc_reset_run_i; // debug entry from reset owned by controller
    end else if (exit_debug) begin
      dbg_src_q <= 1'b0; // source bits clear on debug exit
      mc_src_q <= 1'b0;
      dbg_res_q <= 1'b0;
      mc_res_q <= 1'b0;
    end else if (in_debug | enter_debug) begin
      dbg_src_q <= dbg_src_d;
      mc_src_q <= mc_src_d;
      dbg_res_q <= dbg_res_d & ~dbg_halt_req_i;
      mc_res_q <= mc_res_d;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      mc_halt_s_q <= 1'b0;
      mc_run_s_q <= 1'b0;
      pm_pend_q <= 1'b0;
      brk_q <= 1'b0;
      cause_q <= hrc_pkg::CAUSE_NONE;
      dpc_q <= 32'h0000_0000;
      illegal_q <= 1'b0;
    end else begin
      mc_halt_s_q <= mc_halt_s;
      mc_run_s_q <= mc_run_s;
      // manager halt remembered so controller run can wait on it
      if (pm_run_s) begin
        pm_pend_q <= 1'b0;
      end else if (pm_halt_s) begin
        pm_pend_q <= 1'b1;
      end
      if (enter_debug) begin
        cause_q <= new_cause;
        dpc_q <= next_pc_i;
      end else if (step_end) begin
        cause_q <= hrc_pkg::CAUSE_STEP;
        dpc_q <= next_pc_i;
      end
      // set wins over the exit clear
      if (brkpt_halt_i | trig_halt_i) begin
        brk_q <= 1'b1;
      end else if (exit_debug) begin
        brk_q <= 1'b0;
      end
      illegal_q <= (state_q == hrc_pkg::HRC_STEP) & dmode_reg_acc_i;
    end
  end

  assign pm_halt_done = st_sleep;
  assign pm_run_done = st_run;
  assign mc_halt_done = st_dhalt;
  assign mc_run_done = st_run;

  hrc_handshake u_pm_halt (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .req_i(pm_halt_s),
    .done_i(pm_halt_done),
    .ack_o(pm_halt_ack_o)
  );

  hrc_handshake u_pm_run (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .req_i(pm_run_s),
    .done_i(pm_run_done),
    .ack_o(pm_run_ack_o)
  );

  hrc_handshake u_mc_halt (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .req_i(mc_halt_s),
    .done_i(mc_halt_done),
    .ack_o(mc_halt_ack_o)
  );

  hrc_handshake u_mc_run (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .req_i(mc_run_s),
    .done_i(mc_run_done),
    .ack_o(mc_run_ack_o)
  );

  assign halt_status_o = st_sleep;
  assign debug_mode_o = in_debug;
  assign brkpt_status_o = brk_q;
  assign stall_o = ~st_run & ~st_step;
  assign illegal_acc_o = illegal_q;
  assign dbg_cause_o = cause_q;
  assign dbg_pc_o = dpc_q;
endmodule : hrc_core_halt_run_control

// file: rtl/hrc_handshake.sv
// four-phase acknowledge generator for one request line
`timescale 1ns/1ps
module hrc_handshake (
  input wire logic clock_i, // core clock
  input wire logic rstn_i, // synchronous reset, active low
  input wire logic req_i, // synchronized request level
  input wire logic done_i, // requested action complete
  output logic ack_o // acknowledge, held until request falls
);
  logic ack_q;
  logic ack_d;

  // ack rises once done while request high, falls after request low
  assign ack_d = req_i & (ack_q | done_i);

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= ack_d;
    end
  end

  assign ack_o = ack_q;
endmodule : hrc_handshake

// file: rtl/hrc_sync.sv
// two-flop level synchronizer bank
`timescale 1ns/1ps
module hrc_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clock_i, // free-running core clock
  input wire logic rstn_i, // synchronous reset, active low
  input wire logic [WIDTH-1:0] async_i, // asynchronous levels
  output logic [WIDTH-1:0] sync_o // levels in core domain
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // first stage is read only by the second
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;
endmodule : hrc_sync
